// ==== common/baf_pkg.sv ====
// baf_pkg: constants and types for the byte add/flag unit
// assumes: shared by the unit top, its adder core and their interface
package baf_pkg;
	localparam int BAF_WIDTH = 8;
	localparam int BAF_NIB = 4;
	// add opcodes
	localparam logic [7:0] BAF_OP_ADD_RR = 8'h02;
	localparam logic [7:0] BAF_OP_ADD_RIR = 8'h03;
	localparam logic [7:0] BAF_OP_ADD_GG = 8'h04;
	localparam logic [7:0] BAF_OP_ADD_GIG = 8'h05;
	localparam logic [7:0] BAF_OP_ADD_GIM = 8'h06;
	// add-with-carry opcodes
	localparam logic [7:0] BAF_OP_ADC_RR = 8'h12;
	localparam logic [7:0] BAF_OP_ADC_RIR = 8'h13;
	localparam logic [7:0] BAF_OP_ADC_GG = 8'h14;
	localparam logic [7:0] BAF_OP_ADC_GIG = 8'h15;
	localparam logic [7:0] BAF_OP_ADC_GIM = 8'h16;
	// lengths and cycle counts
	localparam logic [1:0] BAF_LEN_SHORT = 2'h2;
	localparam logic [1:0] BAF_LEN_LONG = 2'h3;
	localparam logic [2:0] BAF_CYC_SHORT = 3'h4;
	localparam logic [2:0] BAF_CYC_LONG = 3'h6;
	// flag vector positions
	localparam int BAF_F_CARRY = 5;
	localparam int BAF_F_ZERO = 4;
	localparam int BAF_F_NEG = 3;
	localparam int BAF_F_OVF = 2;
	localparam int BAF_F_SUB = 1;
	localparam int BAF_F_HALF = 0;
	localparam logic [5:0] BAF_FLAGS_RST = 6'h00;
	localparam logic [7:0] BAF_RESULT_RST = 8'h00;

	typedef enum logic [1:0] {
		BAF_IDLE = 2'b00,
		BAF_WAIT = 2'b01,
		BAF_DONE = 2'b10
	} baf_state_t;
endpackage

// ==== common/baf_core_if.sv ====
// baf_core_if: operands in, sum and flags out of the adder core
// assumes: driven and read on the same clock as the unit top
`timescale 1ns/1ps
interface baf_core_if;
	import baf_pkg::*;
	logic [BAF_WIDTH-1:0] dst;
	logic [BAF_WIDTH-1:0] src;
	logic carry_in;
	logic [BAF_WIDTH-1:0] sum;
	logic [5:0] flags;
	modport unit (output dst, output src, output carry_in, input sum, input flags);
	modport core (input dst, input src, input carry_in, output sum, output flags);
endinterface

// ==== rtl/baf_adder_core.sv ====
// baf_adder_core: combinational 8-bit adder with six flag outputs
// assumes: operands stable from the unit's registers
`timescale 1ns/1ps
module baf_adder_core
	import baf_pkg::*;
(
	baf_core_if.core cif // operands and results
);
	logic [BAF_NIB:0] low_sum;
	logic [BAF_WIDTH:0] full_sum;
	logic [BAF_WIDTH-1:0] res;

	always_comb begin
		low_sum = {1'b0, cif.dst[BAF_NIB-1:0]} + {1'b0, cif.src[BAF_NIB-1:0]}
			+ {{BAF_NIB{1'b0}}, cif.carry_in};
		full_sum = {1'b0, cif.dst} + {1'b0, cif.src}
			+ {{BAF_WIDTH{1'b0}}, cif.carry_in};
		res = full_sum[BAF_WIDTH-1:0];
		cif.sum = res;
		cif.flags[BAF_F_CARRY] = full_sum[BAF_WIDTH];
		cif.flags[BAF_F_ZERO] = (res == 8'h00);
		cif.flags[BAF_F_NEG] = res[BAF_WIDTH-1];
		cif.flags[BAF_F_OVF] = (cif.dst[BAF_WIDTH-1] == cif.src[BAF_WIDTH-1])
			&& (res[BAF_WIDTH-1] != cif.dst[BAF_WIDTH-1]);
		cif.flags[BAF_F_SUB] = 1'b0;
		cif.flags[BAF_F_HALF] = low_sum[BAF_NIB];
	end
endmodule

// ==== rtl/baf_unit.sv ====
// baf_unit: byte add / add-with-carry execution unit with flag update
// assumes: decoder presents opcode and fetched operands with a one-cycle start;
// register file takes dst write-back and flags on the done pulse
`timescale 1ns/1ps
module baf_unit
	import baf_pkg::*;
#(
	parameter int WIDTH = BAF_WIDTH
)(
	input wire logic clock, // 200 MHz core clock
	input wire logic rst_b, // async reset, active low
	input wire logic start, // one-cycle instruction issue
	input wire logic [7:0] opcode, // instruction opcode
	input wire logic [WIDTH-1:0] dst_val, // destination operand
	input wire logic [WIDTH-1:0] src_val, // source operand (register, indirect or immediate)
	input wire logic carry_flag_in, // current carry flag
	output logic busy, // instruction in progress
	output logic wr_en, // one-cycle write-back strobe
	output logic [WIDTH-1:0] wr_data, // result for destination
	output logic [5:0] flags_out, // carry,zero,neg,ovf,sub,half
	output logic [1:0] instr_len, // byte length of accepted form
	output logic illegal // unsupported opcode issued while idle, one cycle
);
	// the flag logic is fixed to one byte, so refuse any other width at elaboration
	if (WIDTH != BAF_WIDTH) begin : g_width_check
		$error("baf_unit supports only an 8-bit datapath");
	end

	////////////////////////////////////////////////////////////////////////
	// opcode decode
	logic op_ok;
	logic op_carry;
	logic [1:0] op_len;
	logic [2:0] op_cyc;

	always_comb begin
		op_ok = 1'b1;
		op_len = BAF_LEN_LONG;
		op_cyc = BAF_CYC_LONG;
		// only the register-pair forms are four cycles; every other form takes six
		case (opcode)
			BAF_OP_ADD_RR: begin
				op_len = BAF_LEN_SHORT;
				op_cyc = BAF_CYC_SHORT;
			end
			BAF_OP_ADD_RIR: begin
				op_len = BAF_LEN_SHORT;
				op_cyc = BAF_CYC_LONG;
			end
			BAF_OP_ADD_GG: begin
				op_len = BAF_LEN_LONG;
				op_cyc = BAF_CYC_LONG;
			end
			BAF_OP_ADD_GIG: begin
				op_len = BAF_LEN_LONG;
				op_cyc = BAF_CYC_LONG;
			end
			BAF_OP_ADD_GIM: begin
				op_len = BAF_LEN_LONG;
				op_cyc = BAF_CYC_LONG;
			end
			// carry forms share the plain forms' lengths and cycle counts
			BAF_OP_ADC_RR: begin
				op_len = BAF_LEN_SHORT;
				op_cyc = BAF_CYC_SHORT;
			end
			BAF_OP_ADC_RIR: begin
				op_len = BAF_LEN_SHORT;
				op_cyc = BAF_CYC_LONG;
			end
			BAF_OP_ADC_GG: begin
				op_len = BAF_LEN_LONG;
				op_cyc = BAF_CYC_LONG;
			end
			BAF_OP_ADC_GIG: begin
				op_len = BAF_LEN_LONG;
				op_cyc = BAF_CYC_LONG;
			end
			BAF_OP_ADC_GIM: begin
				op_len = BAF_LEN_LONG;
				op_cyc = BAF_CYC_LONG;
			end
			default: begin
				op_ok = 1'b0;
			end
		endcase
		// carry forms differ from the plain forms only in bit four
		op_carry = opcode[4] && op_ok;
	end

	////////////////////////////////////////////////////////////////////////
	// operand capture and adder core
	baf_core_if cif ();
	baf_adder_core u_core (.cif(cif));

	logic [WIDTH-1:0] dst_q, dst_d;
	logic [WIDTH-1:0] src_q, src_d;
	logic cin_q, cin_d;

	assign cif.dst = dst_q;
	assign cif.src = src_q;
	assign cif.carry_in = cin_q;

	////////////////////////////////////////////////////////////////////////
	// sequencing: result held until the cycle count elapses, so write-back
	// lands at the documented instruction time
	baf_state_t state_q, state_d;
	logic [2:0] cnt_q, cnt_d;
	logic busy_d, wr_en_d, illegal_d;
	logic [WIDTH-1:0] wr_data_d;
	logic [5:0] flags_d;
	logic [1:0] len_d;

	logic take;

	// operands latch only on an accepted start, so a start refused while
	// busy cannot disturb the instruction in flight
	assign take = (state_q == BAF_IDLE) && start && op_ok;

	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		busy_d = busy;
		wr_en_d = 1'b0;
		len_d = instr_len;
		illegal_d = 1'b0;
		case (state_q)
			BAF_IDLE: begin
				if (take) begin
					// start cycle plus wait plus done cycle make op_cyc
					cnt_d = op_cyc - 3'h2;
					len_d = op_len;
					busy_d = 1'b1;
					state_d = BAF_WAIT;
				end else if (start) begin
					// an unknown code changes nothing but the pulse
					illegal_d = 1'b1;
				end
			end
			BAF_WAIT: begin
				cnt_d = cnt_q - 3'h1;
				if (cnt_q == 3'h1) begin
					state_d = BAF_DONE;
				end
			end
			BAF_DONE: begin
				wr_en_d = 1'b1;
				busy_d = 1'b0;
				state_d = BAF_IDLE;
			end
			default: begin
				state_d = BAF_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= BAF_IDLE;
			cnt_q <= 3'h0;
			busy <= 1'b0;
			wr_en <= 1'b0;
			instr_len <= 2'h0;
			illegal <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			busy <= busy_d;
			wr_en <= wr_en_d;
			instr_len <= len_d;
			illegal <= illegal_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// operand and result registers
	always_comb begin
		dst_d = dst_q;
		src_d = src_q;
		cin_d = cin_q;
		wr_data_d = wr_data;
		flags_d = flags_out;
		if (take) begin
			dst_d = dst_val;
			src_d = src_val; // source only read, never written back
			cin_d = op_carry ? carry_flag_in : 1'b0;
		end
		// sum and flags leave together so the flag file never sees half an update
		if (state_q == BAF_DONE) begin
			wr_data_d = cif.sum;
			flags_d = cif.flags;
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			dst_q <= BAF_RESULT_RST;
			src_q <= BAF_RESULT_RST;
			cin_q <= 1'b0;
			wr_data <= BAF_RESULT_RST;
			flags_out <= BAF_FLAGS_RST;
		end else begin
			dst_q <= dst_d;
			src_q <= src_d;
			cin_q <= cin_d;
			wr_data <= wr_data_d;
			flags_out <= flags_d;
		end
	end
endmodule

// ==== sim/baf_monitor.sv ====
// baf_monitor: port-level checks of sum, flags and latency
// assumes: bound to baf_unit, one clock, async active-low reset
`timescale 1ns/1ps
module baf_monitor
	import baf_pkg::*;
#(
	parameter int WIDTH = BAF_WIDTH
)(
	input wire logic clock, // clk
	input wire logic rst_b, // reset
	input wire logic start, // issue
	input wire logic [7:0] opcode, // opcode
	input wire logic [WIDTH-1:0] dst_val, // dst operand
	input wire logic [WIDTH-1:0] src_val, // src operand
	input wire logic carry_flag_in, // carry in
	input wire logic busy, // busy
	input wire logic wr_en, // write-back
	input wire logic [WIDTH-1:0] wr_data, // result
	input wire logic [5:0] flags_out, // flags
	input wire logic illegal // bad opcode
);
	logic [WIDTH-1:0] d_q, s_q;
	logic c_q;
	wire [WIDTH:0] t = d_q + s_q + c_q;
	wire [4:0] h = d_q[3:0] + s_q[3:0] + c_q;
	// refused starts must not disturb the operands in flight
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			{d_q, s_q, c_q} <= '0;
		end else if (start && !busy) begin
			{d_q, s_q, c_q} <= {dst_val, src_val, carry_flag_in & opcode[4]};
		end
	end
	////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);
	sum_value_a: assert property (wr_en |-> wr_data == t[7:0])
		else $error("wrong sum");
	carry_flag_a: assert property (wr_en |-> flags_out[BAF_F_CARRY] == t[8])
		else $error("wrong carry flag");
	zero_flag_a: assert property (wr_en |-> flags_out[BAF_F_ZERO] == (t[7:0] == 8'h00))
		else $error("wrong zero flag");
	neg_flag_a: assert property (wr_en |-> flags_out[BAF_F_NEG] == t[7])
		else $error("wrong negative flag");
	ovf_flag_a: assert property (wr_en |-> flags_out[BAF_F_OVF] ==
		(d_q[7] == s_q[7] && t[7] != d_q[7])) else $error("wrong overflow flag");
	sub_flag_a: assert property (flags_out[BAF_F_SUB] == 1'b0)
		else $error("subtract flag set");
	half_flag_a: assert property (wr_en |-> flags_out[BAF_F_HALF] == h[4])
		else $error("wrong half carry");
	short_lat_a: assert property (start && !busy && opcode inside {8'h02, 8'h12}
		|=> (busy && !wr_en)[*3] ##1 (wr_en && !busy)) else $error("short form latency");
	long_lat_a: assert property (start && !busy && opcode inside {[8'h03:8'h06], [8'h13:8'h16]}
		|=> (busy && !wr_en)[*5] ##1 (wr_en && !busy)) else $error("long form latency");
	hold_out_a: assert property ($changed({wr_data, flags_out}) |-> wr_en)
		else $error("result changed without write-back");
	cover property (start && !busy && opcode == BAF_OP_ADC_RR && carry_flag_in);
	cover property (wr_en && start);
	cover property (illegal);
endmodule
bind baf_unit baf_monitor #(.WIDTH(WIDTH)) baf_monitor_i (.clock, .rst_b, .start, .opcode,
	.dst_val, .src_val, .carry_flag_in, .busy, .wr_en, .wr_data, .flags_out, .illegal);

// ==== sim/baf_rf_model.sv ====
// baf_rf_model: flag register of the far side, feeds the carry back
// assumes: write-back strobe and flags straight from baf_unit
`timescale 1ns/1ps
module baf_rf_model (
	input wire logic clock, // clk
	input wire logic rst_b, // reset
	input wire logic wr_en, // write-back
	input wire logic [5:0] flags_out, // new flags
	output logic carry_fwd // carry for next issue
);
	logic carry_q;
	// bypass, else a back-to-back carry add reads a stale flag
	assign carry_fwd = wr_en ? flags_out[5] : carry_q;
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) carry_q <= 1'b0;
		else if (wr_en) carry_q <= flags_out[5];
	end
endmodule

// ==== sim/testbench.sv ====
// testbench: table of add forms, then refusal, reset and bad opcode
// assumes: baf_unit with the flag model closing the carry loop
`timescale 1ns/1ps
module testbench;
	import baf_pkg::*;
	logic clock, rst_b, start, carry_flag_in, busy, wr_en, illegal;
	logic [7:0] opcode, dst_val, src_val, wr_data;
	logic [5:0] flags_out;
	logic [1:0] instr_len;
	int n_errors = 0;
	int compares = 0;
	// opcode, dst, src, result, flags; carry in is the previous row's carry
	logic [37:0] rows [10] = '{{8'h04, 8'hff, 8'h01, 8'h00, 6'h31},
		{8'h12, 8'h10, 8'h03, 8'h14, 6'h00}, {8'h03, 8'h12, 8'h0a, 8'h1c, 6'h00},
		{8'h05, 8'h7f, 8'h01, 8'h80, 6'h0d}, {8'h06, 8'h80, 8'h80, 8'h00, 6'h34},
		{8'h02, 8'h12, 8'h03, 8'h15, 6'h00}, {8'h13, 8'h0f, 8'h00, 8'h0f, 6'h00},
		{8'h14, 8'hf0, 8'h10, 8'h00, 6'h30}, {8'h15, 8'h7e, 8'h01, 8'h80, 6'h0d},
		{8'h16, 8'h20, 8'h11, 8'h31, 6'h00}};
	baf_unit baf_unit_i (.clock, .rst_b, .start, .opcode, .dst_val, .src_val, .carry_flag_in,
		.busy, .wr_en, .wr_data, .flags_out, .instr_len, .illegal);
	baf_rf_model baf_rf_model_i (.clock, .rst_b, .wr_en, .flags_out, .carry_fwd(carry_flag_in));
	always #2.5 clock = ~clock;
	////////////////////////////////////////////////////////////////
	task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task report_and_stop;
		if (n_errors == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// start stays up for hold cycles; the extra ones must be ignored
	task automatic do_op(input logic [37:0] r, input int hold);
		int k;
		logic [1:0] len;
		k = 0;
		len = (r[32:30] > 3'h3) ? BAF_LEN_LONG : BAF_LEN_SHORT;
		{opcode, dst_val, src_val} = r[37:14];
		start = 1'b1;
		do begin
			@(negedge clock);
			k++;
			if (k >= hold) start = 1'b0;
		end while (wr_en !== 1'b1 && k < 20);
		check("latency", 16'(k), (r[32:30] == 3'h2) ? 16'h4 : 16'h6);
		check("result", {wr_data, flags_out, instr_len}, {r[13:0], len});
	endtask
	initial begin
		#10000;
		n_errors++;
		report_and_stop;
	end
	initial begin
		{clock, rst_b, start, opcode, dst_val, src_val} = '0;
		repeat (3) @(negedge clock);
		rst_b = 1'b1;
		foreach (rows[i]) do_op(rows[i], 1);
		do_op(rows[0], 3);
		@(negedge clock);
		start = 1'b1;
		@(negedge clock);
		start = 1'b0;
		@(negedge clock);
		rst_b = 1'b0;
		#1;
		check("reset", {busy, wr_en, wr_data, flags_out}, 16'h0);
		check("reset len", 16'(instr_len), 16'h0);
		@(negedge clock);
		rst_b = 1'b1;
		opcode = 8'h07;
		start = 1'b1;
		@(negedge clock);
		start = 1'b0;
		check("refused", {busy, wr_en, illegal, wr_data, 5'h0}, 16'h2000);
		@(negedge clock);
		check("illegal", 16'(illegal), 16'h0);
		report_and_stop;
	end
endmodule
